// file: pkg/tsf_pkg.sv
/*
  Shared constants, register map and carrier types of the terminal stream block.
  Assumes an 8-bit register port and 8-bit characters on every stream.
*/
package tsf_pkg;
  localparam logic [3:0] TSF_REG_CTRL      = 4'h0;
  localparam logic [3:0] TSF_REG_RESUME    = 4'h1;
  localparam logic [3:0] TSF_REG_HALT      = 4'h2;
  localparam logic [3:0] TSF_REG_SELECT    = 4'h3;
  localparam logic [3:0] TSF_REG_SCHED_MIN = 4'h4;
  localparam logic [3:0] TSF_REG_SCHED_PUSH = 4'h5;
  localparam logic [3:0] TSF_REG_SCHED_CLR = 4'h6;
  localparam logic [3:0] TSF_REG_STATUS    = 4'h7;
  localparam logic [3:0] TSF_REG_SCHED_LEN = 4'h8;

  localparam int TSF_CTRL_TAG  = 0;
  localparam int TSF_CTRL_DBL  = 1;
  localparam int TSF_CTRL_DUMP = 2;
  localparam int TSF_CTRL_FLOW = 3;
  localparam int TSF_ST_HALT   = 0;
  localparam int TSF_ST_RAW    = 1;
  localparam int TSF_ST_PEND   = 2;
  localparam int TSF_ST_BUSY   = 3;

  localparam logic [3:0] TSF_CTRL_RST   = 4'h0;
  localparam logic [6:0] TSF_RESUME_RST = 7'h11;
  localparam logic [6:0] TSF_HALT_RST   = 7'h13;
  localparam logic [7:0] TSF_SELECT_RST = 8'h7C;
  localparam logic [5:0] TSF_MIN_OFF    = 6'h3C;
  localparam logic [5:0] TSF_MIN_RST    = 6'h3C;
  localparam logic [5:0] TSF_SEC_FIRE   = 6'h01;

  localparam logic [7:0] TSF_CH_COLON = 8'h3A;
  localparam logic [7:0] TSF_CH_SPACE = 8'h20;
  localparam logic [7:0] TSF_CH_CR    = 8'h0D;
  localparam logic [7:0] TSF_CH_LF    = 8'h0A;
  localparam logic [7:0] TSF_CH_DOT   = 8'h2E;
  localparam logic [7:0] TSF_CH_TILDE = 8'h7E;
  localparam logic [7:0] TSF_CH_A     = 8'h41;

  localparam int TSF_SCHED_MAX = 119;
  localparam int TSF_DUMP_LINE = 16;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tsf_bus_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tsf_chr_t;

  typedef enum logic [7:0] {
    F_IDLE = 8'h01, F_SEL = 8'h02, F_CHN = 8'h04, F_C1 = 8'h08,
    F_CALL = 8'h10, F_C2 = 8'h20, F_DATA = 8'h40, F_DBL = 8'h80
  } tsf_fmt_t;

  typedef enum logic [6:0] {
    D_FILL = 7'h01, D_OFS = 7'h02, D_HEX = 7'h04, D_SHF = 7'h08,
    D_SP = 7'h10, D_ASC = 7'h20, D_EOL = 7'h40
  } tsf_dmp_t;
endpackage

// file: rtl/tsf_dump.sv
/*
  Frame dump line builder: collects up to one line of frame bytes and prints
  offset, hex bytes, shifted and plain character columns, then CR LF.
  Assumes bytes arrive as a valid/ready stream with a last flag per frame.
*/
`timescale 1ns/10ps
`default_nettype none
module tsf_dump #(
  parameter int LINE = tsf_pkg::TSF_DUMP_LINE
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire tsf_pkg::tsf_chr_t byte_in,
  input  wire logic              byte_last,
  output logic                   byte_ready,
  output tsf_pkg::tsf_chr_t      chr_out,
  input  wire logic              chr_ready,
  output logic                   busy
);
  import tsf_pkg::*;

  if (LINE != 16) begin : g_chk
    $error("tsf_dump supports a line of 16 bytes only");
  end

  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  function automatic logic [7:0] prc(input logic [6:0] c);
    prc = ({1'b0, c} >= TSF_CH_SPACE && {1'b0, c} < TSF_CH_TILDE + 8'h01) ? {1'b0, c}
                                                                           : TSF_CH_DOT;
  endfunction

  tsf_dmp_t   st_r, st_nxt;
  logic [7:0] buf_r [LINE];
  logic [7:0] buf_nxt [LINE];
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [1:0] sub_r, sub_nxt;
  logic       last_r, last_nxt;
  tsf_chr_t   out_r, out_nxt;
  logic       slot;
  logic [7:0] cur;
  logic       lastb;

  assign byte_ready = (st_r == D_FILL);
  assign chr_out    = out_r;
  assign busy       = (st_r != D_FILL) || (cnt_r != 5'h00);
  assign slot       = !out_r.valid || chr_ready;
  assign cur        = buf_r[idx_r];
  assign lastb      = ({1'b0, idx_r} == cnt_r - 5'h01);

  always_comb begin
    st_nxt = st_r;
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    ofs_nxt = ofs_r;
    idx_nxt = idx_r;
    sub_nxt = sub_r;
    last_nxt = last_r;
    out_nxt = out_r;
    if (out_r.valid && chr_ready) begin
      out_nxt.valid = 1'b0;
    end
    case (st_r)
      D_FILL: begin
        if (byte_in.valid) begin
          buf_nxt[cnt_r[3:0]] = byte_in.data;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == 5'(LINE - 1) || byte_last) begin
            st_nxt = D_OFS;
            idx_nxt = 4'h0;
            last_nxt = byte_last;
          end
        end
      end
      D_OFS: if (slot) begin
        // The offset prints as four hex digits and one space.
        out_nxt = {1'b1, (idx_r == 4'h4) ? TSF_CH_SPACE : hexc(ofs_r[4'(4'hC - {idx_r[1:0], 2'b00}) +: 4])};
        idx_nxt = idx_r + 4'h1;
        if (idx_r == 4'h4) begin
          st_nxt = D_HEX;
          idx_nxt = 4'h0;
          sub_nxt = 2'h0;
        end
      end
      D_HEX: if (slot) begin
        if ({1'b0, idx_r} < cnt_r && sub_r != 2'h2) begin
          out_nxt = {1'b1, hexc(sub_r[0] ? cur[3:0] : cur[7:4])};
        end else begin
          out_nxt = {1'b1, TSF_CH_SPACE};
        end
        sub_nxt = (sub_r == 2'h2) ? 2'h0 : sub_r + 2'h1;
        if (sub_r == 2'h2) begin
          idx_nxt = idx_r + 4'h1;
          if (idx_r == 4'(LINE - 1)) begin
            st_nxt = D_SHF;
            idx_nxt = 4'h0;
          end
        end
      end
      D_SHF: if (slot) begin
        out_nxt = {1'b1, prc(cur[7:1])};
        idx_nxt = idx_r + 4'h1;
        if (lastb) begin
          st_nxt = D_SP;
        end
      end
      D_SP: if (slot) begin
        out_nxt = {1'b1, TSF_CH_SPACE};
        st_nxt = D_ASC;
        idx_nxt = 4'h0;
      end
      D_ASC: if (slot) begin
        out_nxt = {1'b1, prc(cur[6:0])};
        idx_nxt = idx_r + 4'h1;
        if (lastb) begin
          st_nxt = D_EOL;
          sub_nxt = 2'h0;
        end
      end
      D_EOL: if (slot) begin
        out_nxt = {1'b1, sub_r[0] ? TSF_CH_LF : TSF_CH_CR};
        sub_nxt = 2'h1;
        if (sub_r[0]) begin
          st_nxt = D_FILL;
          cnt_nxt = 5'h00;
          ofs_nxt = last_r ? 16'h0000 : ofs_r + {11'h000, cnt_r};
        end
      end
      default: st_nxt = D_FILL;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= D_FILL;
      cnt_r <= 5'h00;
      ofs_r <= 16'h0000;
      idx_r <= 4'h0;
      sub_r <= 2'h0;
      last_r <= 1'b0;
      out_r <= '0;
      for (int i = 0; i < LINE; i++) buf_r[i] <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ofs_r <= ofs_nxt;
      idx_r <= idx_nxt;
      sub_r <= sub_nxt;
      last_r <= last_nxt;
      out_r <= out_nxt;
      buf_r <= buf_nxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_dump_fill_cap: assert property (cnt_r <= 5'(LINE))
    else $error("dump line holds more than one line of bytes");
  chk_dump_dot_cols: assert property ($past(st_r == D_SHF || st_r == D_ASC) && $past(slot)
      |-> out_r.data >= TSF_CH_SPACE && out_r.data <= TSF_CH_TILDE)
    else $error("decode column printed a non-printing code");
endmodule
`default_nettype wire

// file: rtl/tsf_term_stream.sv
/*
  Terminal side character handling: in-band halt and resume of terminal
  output, channel header and select-character doubling on output, raw
  passthrough mode, scheduled command playback and frame dump display.
  Assumes the serial port is a character valid/ready stream on one clock and
  the time-of-day clock supplies minutes and seconds in binary.
*/
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Receiving the resume character restarts halted terminal output; default 11h.
// - Receiving the halt character stops terminal output; default 13h.
// - Both characters zero disables in-band control; only clear-to-send counts.
// - Equal halt and resume codes toggle output on each reception.
// - Tagging on inserts colon, peer callsign, colon after channel letter.
// - Doubling on emits each received select character twice.
// - Select character defaults 7Ch; in raw mode it passes as data.
// - Stored command, up to 119 characters, plays at matching minute, second one.
// - Minute setting 0 to 60, default 60; 60 disables playback.
// - Dump shows whole frames: offset then sixteen hex bytes per line.
// - Dump adds shifted and plain decode columns; unprintables show a period.
// - Passthrough command enters raw mode without touching link state.
// - Raw mode disables editing, echo and, unless the flow bit is set, typed-in flow control.
// - In-band control off in raw mode makes every character plain data.
module tsf_term_stream #(
  parameter int SCHED_DEPTH = tsf_pkg::TSF_SCHED_MAX
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire tsf_pkg::tsf_bus_t bus,
  output logic [7:0]             rd_data,
  input  wire tsf_pkg::tsf_chr_t term_rx,
  input  wire logic              cts,
  output tsf_pkg::tsf_chr_t      term_tx,
  input  wire logic              term_tx_ready,
  output tsf_pkg::tsf_chr_t      link_tx,
  output logic                   chan_switch,
  input  wire logic              passthru_cmd,
  input  wire logic              escape_cmd,
  output logic                   raw_mode,
  output logic                   echo_en,
  output logic                   edit_en,
  input  wire logic              rem_valid,
  input  wire logic              rem_hdr,
  input  wire logic [3:0]        rem_chan,
  input  wire logic [47:0]       rem_call,
  input  wire logic [7:0]        rem_data,
  output logic                   rem_ready,
  input  wire tsf_pkg::tsf_chr_t frm,
  input  wire logic              frm_last,
  output logic                   frm_ready,
  input  wire logic [5:0]        tod_min,
  input  wire logic [5:0]        tod_sec,
  input  wire logic              user_typing,
  output tsf_pkg::tsf_chr_t      cmd_out,
  input  wire logic              cmd_ready
);
  import tsf_pkg::*;

  if (SCHED_DEPTH < 1 || SCHED_DEPTH > 127) begin : g_chk
    $error("scheduled command depth must be 1 to 127");
  end

  // Configuration and register read-back.
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [6:0] res_r, res_nxt;
  logic [6:0] hlt_r, hlt_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [5:0] min_r, min_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic       halted_r, raw_r, pend_r, busy_r;
  logic [6:0] len_r;

  assign rd_data = rd_r;

  always_comb begin
    ctrl_nxt = ctrl_r;
    res_nxt = res_r;
    hlt_nxt = hlt_r;
    sel_nxt = sel_r;
    min_nxt = min_r;
    rd_nxt = 8'h00;
    if (bus.wr) begin
      if (bus.addr == TSF_REG_CTRL) ctrl_nxt = bus.wdata[3:0];
      else if (bus.addr == TSF_REG_RESUME) res_nxt = bus.wdata[6:0];
      else if (bus.addr == TSF_REG_HALT) hlt_nxt = bus.wdata[6:0];
      else if (bus.addr == TSF_REG_SELECT) sel_nxt = bus.wdata;
      // Minutes above 60 are out of range and ignored.
      else if (bus.addr == TSF_REG_SCHED_MIN && bus.wdata <= {2'b00, TSF_MIN_OFF}) begin
        min_nxt = bus.wdata[5:0];
      end
    end
    if (bus.rd) begin
      if (bus.addr == TSF_REG_CTRL) rd_nxt = {4'h0, ctrl_r};
      else if (bus.addr == TSF_REG_RESUME) rd_nxt = {1'b0, res_r};
      else if (bus.addr == TSF_REG_HALT) rd_nxt = {1'b0, hlt_r};
      else if (bus.addr == TSF_REG_SELECT) rd_nxt = sel_r;
      else if (bus.addr == TSF_REG_SCHED_MIN) rd_nxt = {2'b00, min_r};
      else if (bus.addr == TSF_REG_STATUS) rd_nxt = {4'h0, busy_r, pend_r, raw_r, halted_r};
      else if (bus.addr == TSF_REG_SCHED_LEN) rd_nxt = {1'b0, len_r};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= TSF_CTRL_RST;
      res_r <= TSF_RESUME_RST;
      hlt_r <= TSF_HALT_RST;
      sel_r <= TSF_SELECT_RST;
      min_r <= TSF_MIN_RST;
      rd_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      res_r <= res_nxt;
      hlt_r <= hlt_nxt;
      sel_r <= sel_nxt;
      min_r <= min_nxt;
      rd_r <= rd_nxt;
    end
  end

  // Terminal input: flow control, local channel switch and data toward the link.
  logic     halted_nxt, raw_nxt, sw_r, sw_nxt;
  tsf_chr_t link_r, link_nxt;
  logic     flow_off, flow_act, is_res, is_hlt, flow_hit;

  assign flow_off = (res_r == 7'h00) && (hlt_r == 7'h00);
  assign flow_act = !flow_off && (!raw_r || ctrl_r[TSF_CTRL_FLOW]);
  assign is_res   = (term_rx.data == {1'b0, res_r});
  assign is_hlt   = (term_rx.data == {1'b0, hlt_r});
  assign flow_hit = term_rx.valid && flow_act && (is_res || is_hlt);
  assign raw_mode = raw_r;
  assign echo_en  = !raw_r;
  assign edit_en  = !raw_r;
  assign link_tx  = link_r;
  assign chan_switch = sw_r;

  always_comb begin
    halted_nxt = halted_r;
    raw_nxt = raw_r;
    link_nxt = '0;
    sw_nxt = 1'b0;
    // Only the mode bit moves; link and channel state are left as they are.
    if (escape_cmd) raw_nxt = 1'b0;
    else if (passthru_cmd) raw_nxt = 1'b1;
    if (flow_off) begin
      halted_nxt = 1'b0;
    end else if (flow_hit) begin
      if (is_res && is_hlt) halted_nxt = !halted_r;
      else if (is_hlt) halted_nxt = 1'b1;
      else halted_nxt = 1'b0;
    end
    if (term_rx.valid && !flow_hit) begin
      if (!raw_r && term_rx.data == sel_r) sw_nxt = 1'b1;
      else link_nxt = term_rx;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      halted_r <= 1'b0;
      raw_r <= 1'b0;
      link_r <= '0;
      sw_r <= 1'b0;
    end else begin
      halted_r <= halted_nxt;
      raw_r <= raw_nxt;
      link_r <= link_nxt;
      sw_r <= sw_nxt;
    end
  end

  // Terminal output: channel header formatter, dump lines and one held character.
  tsf_fmt_t   fmt_r, fmt_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [47:0] call_r, call_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic [2:0] cidx_r, cidx_nxt;
  tsf_chr_t   out_r, out_nxt, dmp;
  logic       load, take, emit_v, dmp_ready, dmp_busy, dump_on, dmp_fill;
  logic [7:0] emit_d, callc;

  assign dump_on = ctrl_r[TSF_CTRL_DUMP];
  // A held character is offered only while running; once taken it is the
  // serialiser's to finish, so a halt never cuts a character in half.
  assign term_tx = {out_r.valid && !halted_r && cts, out_r.data};
  assign take    = term_tx.valid && term_tx_ready;
  assign load    = !out_r.valid || take;
  assign callc   = call_r[8 * (5 - int'(cidx_r)) +: 8];
  assign rem_ready = (fmt_r == F_IDLE) && !dmp_busy;
  assign frm_ready = dump_on ? dmp_fill : 1'b1;

  tsf_dump u_dump (
    .clock      (clock),
    .rst_n      (rst_n),
    .byte_in    ({frm.valid && dump_on, frm.data}),
    .byte_last  (frm_last),
    .byte_ready (dmp_fill),
    .chr_out    (dmp),
    .chr_ready  (dmp_ready),
    .busy       (dmp_busy)
  );

  always_comb begin
    fmt_nxt = fmt_r;
    chan_nxt = chan_r;
    call_nxt = call_r;
    byte_nxt = byte_r;
    cidx_nxt = cidx_r;
    emit_v = 1'b0;
    emit_d = 8'h00;
    case (fmt_r)
      F_IDLE: if (rem_valid && rem_ready) begin
        if (rem_hdr) begin
          chan_nxt = rem_chan;
          call_nxt = rem_call;
          fmt_nxt = F_SEL;
        end else begin
          byte_nxt = rem_data;
          fmt_nxt = F_DATA;
        end
      end
      F_SEL: begin
        emit_v = 1'b1;
        emit_d = sel_r;
        if (load) fmt_nxt = F_CHN;
      end
      F_CHN: begin
        emit_v = 1'b1;
        emit_d = TSF_CH_A + {4'h0, chan_r};
        if (load) fmt_nxt = ctrl_r[TSF_CTRL_TAG] ? F_C1 : F_IDLE;
      end
      F_C1: begin
        emit_v = 1'b1;
        emit_d = TSF_CH_COLON;
        cidx_nxt = 3'h0;
        if (load) fmt_nxt = F_CALL;
      end
      F_CALL: begin
        // Trailing spaces pad short callsigns and are not printed.
        if (callc == TSF_CH_SPACE) begin
          fmt_nxt = F_C2;
        end else begin
          emit_v = 1'b1;
          emit_d = callc;
          if (load) begin
            cidx_nxt = cidx_r + 3'h1;
            if (cidx_r == 3'h5) fmt_nxt = F_C2;
          end
        end
      end
      F_C2: begin
        emit_v = 1'b1;
        emit_d = TSF_CH_COLON;
        if (load) fmt_nxt = F_IDLE;
      end
      F_DATA: begin
        emit_v = 1'b1;
        emit_d = byte_r;
        if (load) fmt_nxt = (ctrl_r[TSF_CTRL_DBL] && byte_r == sel_r) ? F_DBL : F_IDLE;
      end
      F_DBL: begin
        emit_v = 1'b1;
        emit_d = byte_r;
        if (load) fmt_nxt = F_IDLE;
      end
      default: fmt_nxt = F_IDLE;
    endcase
    out_nxt = out_r;
    if (take) out_nxt.valid = 1'b0;
    // Dump text waits for an idle formatter so that a header is never split.
    dmp_ready = load && (fmt_r == F_IDLE);
    if (load && emit_v) out_nxt = {1'b1, emit_d};
    else if (dmp_ready && dmp.valid) out_nxt = dmp;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fmt_r <= F_IDLE;
      chan_r <= 4'h0;
      call_r <= 48'h0;
      byte_r <= 8'h00;
      cidx_r <= 3'h0;
      out_r <= '0;
    end else begin
      fmt_r <= fmt_nxt;
      chan_r <= chan_nxt;
      call_r <= call_nxt;
      byte_r <= byte_nxt;
      cidx_r <= cidx_nxt;
      out_r <= out_nxt;
    end
  end

  // Scheduled command string: stored in flip-flops, played out at the set minute.
  logic [7:0] mem_r [SCHED_DEPTH];
  logic [7:0] mem_nxt [SCHED_DEPTH];
  logic [6:0] len_nxt, sidx_r, sidx_nxt;
  logic       pend_nxt, busy_nxt, cond_r, fire, start;
  tsf_chr_t   cmd_r, cmd_nxt;

  assign fire    = (tod_min == min_r) && (tod_sec == TSF_SEC_FIRE) && (min_r != TSF_MIN_OFF)
                   && !cond_r;
  assign start   = pend_r && !user_typing && !busy_r;
  assign cmd_out = cmd_r;

  always_comb begin
    mem_nxt = mem_r;
    len_nxt = len_r;
    sidx_nxt = sidx_r;
    busy_nxt = busy_r;
    cmd_nxt = cmd_r;
    pend_nxt = pend_r;
    // Editing the string during playback is refused to keep the output whole.
    if (bus.wr && !busy_r) begin
      if (bus.addr == TSF_REG_SCHED_PUSH && len_r < 7'(SCHED_DEPTH)) begin
        mem_nxt[len_r] = bus.wdata;
        len_nxt = len_r + 7'h01;
      end else if (bus.addr == TSF_REG_SCHED_CLR) begin
        len_nxt = 7'h00;
      end
    end
    if (start) begin
      pend_nxt = 1'b0;
      if (len_r != 7'h00) begin
        busy_nxt = 1'b1;
        sidx_nxt = 7'h00;
        cmd_nxt = {1'b1, mem_r[0]};
      end
    end else if (busy_r && cmd_ready) begin
      if (sidx_r == len_r - 7'h01) begin
        busy_nxt = 1'b0;
        cmd_nxt.valid = 1'b0;
      end else begin
        sidx_nxt = sidx_r + 7'h01;
        cmd_nxt = {1'b1, mem_r[sidx_r + 7'h01]};
      end
    end
    if (fire) pend_nxt = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      len_r <= 7'h00;
      sidx_r <= 7'h00;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      cond_r <= 1'b0;
      cmd_r <= '0;
      for (int i = 0; i < SCHED_DEPTH; i++) mem_r[i] <= 8'h00;
    end else begin
      len_r <= len_nxt;
      sidx_r <= sidx_nxt;
      busy_r <= busy_nxt;
      pend_r <= pend_nxt;
      cond_r <= (tod_min == min_r) && (tod_sec == TSF_SEC_FIRE);
      cmd_r <= cmd_nxt;
      mem_r <= mem_nxt;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_sel_rx;
    fmt_r == F_DATA && load && ctrl_r[TSF_CTRL_DBL] && byte_r == sel_r;
  endsequence
  sequence s_twice;
    out_r.valid && out_r.data == sel_r && fmt_r == F_DBL;
  endsequence

  chk_halt_stops: assert property (flow_hit && !flow_off && is_hlt && !is_res
      |=> halted_r && !term_tx.valid)
    else $error("halt character did not stop output");
  chk_resume_runs: assert property (flow_hit && !flow_off && is_res && !is_hlt
      |=> !halted_r)
    else $error("resume character did not restart output");
  chk_same_toggle: assert property (flow_hit && !flow_off && is_res && is_hlt
      |=> halted_r != $past(halted_r))
    else $error("shared code did not toggle output");
  chk_zero_no_halt: assert property (flow_off |=> !halted_r)
    else $error("output halted with in-band control off");
  chk_cts_gate: assert property (!cts || halted_r |-> !term_tx.valid)
    else $error("character offered while halted or clear-to-send low");
  chk_raw_select: assert property (raw_r && term_rx.valid && !flow_hit && term_rx.data == sel_r
      |=> link_tx.valid && !chan_switch)
    else $error("select character not passed as data in raw mode");
  chk_raw_enter: assert property (passthru_cmd && !escape_cmd |=> raw_r && !echo_en)
    else $error("passthrough command did not enter raw mode");
  chk_dbl_twice: assert property (s_sel_rx |=> s_twice)
    else $error("received select character not doubled");
  chk_tag_colon: assert property (fmt_r == F_CHN && load && ctrl_r[TSF_CTRL_TAG]
      |=> fmt_r == F_C1)
    else $error("callsign tag not entered after the channel letter");
  chk_tag_open: assert property (fmt_r == F_C1 && load
      |=> out_r.valid && out_r.data == TSF_CH_COLON)
    else $error("callsign tag not started with a colon");
  chk_sched_defer: assert property ($rose(busy_r) |-> $past(!user_typing) && $past(pend_r))
    else $error("scheduled command started while user typing");
  chk_sched_off: assert property (min_r == TSF_MIN_OFF && !pend_r |=> !pend_r)
    else $error("scheduled command armed with minute setting 60");
endmodule
`default_nettype wire

// file: bench/tsf_term_model.sv
/* Terminal model that takes output characters and can stall.
   Assumes term_tx is offered on the rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module tsf_term_model (
  input  wire logic              clock,
  input  wire logic              slow,
  input  wire tsf_pkg::tsf_chr_t term_tx,
  output logic                   ready,
  output logic [7:0]             last_chr,
  output logic [7:0]             n_chr
);
  import tsf_pkg::*;
  initial ready = 1'b0;
  initial last_chr = 8'h00;
  initial n_chr = 8'h00;
  // A slow terminal accepts only every other cycle.
  always @(posedge clock) begin
    ready <= slow ? !ready : 1'b1;
    if (term_tx.valid && ready) begin
      last_chr <= term_tx.data;
      n_chr <= n_chr + 8'h01;
    end
  end
endmodule
`default_nettype wire

// file: bench/tsf_term_stream_tb.sv
/* Bench for the terminal stream block with a terminal model on its output.
   Assumes a 40 MHz clock and synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module tsf_term_stream_tb;
  import tsf_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, cts = 1'b1, pass = 1'b0, esc = 1'b0, hdr = 1'b0;
  logic flast = 1'b0;
  logic rv = 1'b0, typing = 1'b0, slow = 1'b1, rdy, sw, raw, echo, edit, rrdy, frdy;
  logic [5:0] tmin = 6'h00, tsec = 6'h00;
  logic [7:0] rd_data, rdat = 8'h00, lastc, nchr, n0;
  tsf_bus_t bus = '0;
  tsf_chr_t rx = '0, fb = '0, tx, ltx, cmd;
  int n_fail = 0, checked = 0;
  always #12.5 clock = ~clock;
  tsf_term_stream dut (.clock(clock), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
    .term_rx(rx), .cts(cts), .term_tx(tx), .term_tx_ready(rdy), .link_tx(ltx),
    .chan_switch(sw), .passthru_cmd(pass), .escape_cmd(esc), .raw_mode(raw),
    .echo_en(echo), .edit_en(edit), .rem_valid(rv), .rem_hdr(hdr),
    .rem_chan(4'h1), .rem_call(48'h414220202020), .rem_data(rdat), .rem_ready(rrdy),
    .frm(fb), .frm_last(flast), .frm_ready(frdy), .tod_min(tmin),
    .tod_sec(tsec), .user_typing(typing), .cmd_out(cmd), .cmd_ready(1'b1));
  tsf_term_model term (.clock(clock), .slow(slow), .term_tx(tx), .ready(rdy),
    .last_chr(lastc), .n_chr(nchr));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("n_fail=%0d checked=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clock) bus <= '0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock) bus <= '0;
    #1 chk(rd_data, e);
  endtask
  task automatic key(input logic [7:0] c);
    @(posedge clock) rx <= '{1'b1, c};
    @(posedge clock) rx <= '0;
    #1;
  endtask
  // Sends one remote data byte, then lets the terminal drain it.
  task automatic rem(input logic [7:0] d);
    n0 = nchr;
    @(posedge clock) rv <= 1'b1;
    rdat <= d;
    #1 while (!rrdy) @(posedge clock) #1;
    @(posedge clock) rv <= 1'b0;
    repeat (30) @(posedge clock);
  endtask
  task automatic t_regs();
    rc(TSF_REG_RESUME, 8'h11);
    rc(TSF_REG_HALT, 8'h13);
    rc(TSF_REG_SELECT, 8'h7C);
    wr(TSF_REG_SCHED_MIN, 8'h3D);
    rc(TSF_REG_SCHED_MIN, 8'h3C);
    rc(4'hF, 8'h00);
  endtask
  task automatic t_flow();
    key(8'h13);
    rc(TSF_REG_STATUS, 8'h01);
    rem(8'h61);
    chk(nchr, n0);
    key(8'h11);
    repeat (20) @(posedge clock);
    chk(nchr, n0 + 8'h01);
    wr(TSF_REG_RESUME, 8'h13);
    key(8'h13);
    rc(TSF_REG_STATUS, 8'h01);
    key(8'h13);
    rc(TSF_REG_STATUS, 8'h00);
    wr(TSF_REG_RESUME, 8'h00);
    wr(TSF_REG_HALT, 8'h00);
    key(8'h00);
    cts <= 1'b0;
    rem(8'h62);
    chk(nchr, n0);
    cts <= 1'b1;
    repeat (20) @(posedge clock);
    chk(nchr, n0 + 8'h01);
    wr(TSF_REG_RESUME, 8'h11);
    wr(TSF_REG_HALT, 8'h13);
  endtask
  task automatic t_dbl();
    wr(TSF_REG_CTRL, 8'h02);
    rem(8'h7C);
    chk(nchr, n0 + 8'h02);
    chk(lastc, 8'h7C);
    wr(TSF_REG_CTRL, 8'h01);
    hdr <= 1'b1;
    rem(8'h00);
    hdr <= 1'b0;
    chk(nchr, n0 + 8'h06);
    chk(lastc, TSF_CH_COLON);
    wr(TSF_REG_CTRL, 8'h00);
  endtask
  task automatic t_raw();
    @(posedge clock) pass <= 1'b1;
    @(posedge clock) pass <= 1'b0;
    #1 chk({raw, echo, edit}, 8'h04);
    key(8'h7C);
    chk({ltx.valid, sw, ltx.data[5:0]}, 8'hBC);
    key(8'h13);
    chk(ltx.data, 8'h13);
    rc(TSF_REG_STATUS, 8'h02);
    wr(TSF_REG_CTRL, 8'h08);
    key(8'h13);
    rc(TSF_REG_STATUS, 8'h03);
    key(8'h11);
    rc(TSF_REG_STATUS, 8'h02);
    wr(TSF_REG_CTRL, 8'h00);
    @(posedge clock) esc <= 1'b1;
    @(posedge clock) esc <= 1'b0;
  endtask
  task automatic t_sched();
    logic [15:0] v = 16'h0000;
    wr(TSF_REG_SCHED_PUSH, 8'h58);
    wr(TSF_REG_SCHED_PUSH, 8'h59);
    wr(TSF_REG_SCHED_MIN, 8'h05);
    typing <= 1'b1;
    tmin <= 6'h05;
    tsec <= 6'h01;
    repeat (6) @(posedge clock);
    chk({7'h00, cmd.valid}, 8'h00);
    typing <= 1'b0;
    repeat (12) begin
      @(posedge clock) #1;
      if (cmd.valid === 1'b1) v = {v[7:0], cmd.data};
    end
    chk(v[15:8], 8'h58);
    chk(v[7:0], 8'h59);
  endtask
  // One single-byte frame prints one full line of 58 characters.
  task automatic t_dump();
    wr(TSF_REG_CTRL, 8'h04);
    n0 = nchr;
    @(posedge clock) fb <= '{1'b1, 8'hC1};
    flast <= 1'b1;
    #1 chk({7'h00, frdy}, 8'h01);
    @(posedge clock) fb <= '0;
    flast <= 1'b0;
    #1 chk({7'h00, frdy}, 8'h00);
    repeat (200) @(posedge clock);
    chk(nchr - n0, 8'h3A);
    chk(lastc, TSF_CH_LF);
    wr(TSF_REG_CTRL, 8'h00);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_flow();
    t_dbl();
    t_raw();
    t_sched();
    t_dump();
    stop_test();
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
